// >>> src/cc0_pkg.sv
// Package of constants for the CAN control register zero block.
package cc0_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CC0_ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] CC0_ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] CC0_ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] CC0_ADDR_TIMESTAMP = 8'h0c;
  localparam logic [7:0] CC0_ADDR_INIT = 8'h10;
  // ----------------------------------------
  // Field positions of the control register
  // ----------------------------------------
  localparam int CC0_BIT_RECEIVED_FRAME_FLAG = 7;
  localparam int CC0_BIT_RECEIVER_ACTIVE_STATUS = 6;
  localparam int CC0_BIT_STOPWAIT = 5;
  localparam int CC0_BIT_SYNC = 4;
  localparam int CC0_BIT_TIMER = 3;
  localparam int CC0_BIT_WAKE = 2;
  localparam int CC0_BIT_SLEEP = 1;
  localparam int CC0_BIT_INIT_REQUEST = 0;
  // ----------------------------------------
  // Interrupt status bits
  // ----------------------------------------
  localparam int CC0_IRQ_RXFRAME = 0;
  localparam int CC0_IRQ_SYNC = 1;
  localparam int CC0_IRQ_STAMP = 2;
  localparam int CC0_IRQ_W = 3;
  // ----------------------------------------
  // Reset values and sizes
  // ----------------------------------------
  localparam int CC0_TS_W = 16;
  localparam logic [CC0_TS_W-1:0] CC0_TS_RESET = 16'h0000;
  localparam logic [CC0_IRQ_W-1:0] CC0_IRQ_RESET = 3'h0;
  localparam logic [31:0] CC0_WORD_ZERO = 32'h0000_0000;
  localparam int CC0_INIT_DELAY_DEFAULT = 4;
endpackage

// >>> src/cc0_ctrl.sv
// CAN control register zero with flags, stop-in-wait gating and timestamp timer.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Valid received message sets received frame flag.
// - Received frame flag sticks until cleared.
// - Write one clears flag, zero ignored.
// - Receiver active follows front end reception.
// - Receiver active zero when transmitting or idle.
// - Stop in wait gates bus interface clock.
// - Synchronized status set by device only.
// - Timer enable runs 16-bit bit-rate counter.
// - Acknowledged message receives timestamp write.
// - Disabled timer clears counter to zero.
// - Timer enable forced low in init.
// - Register held reset during init mode, except wake, sleep and init request.
// - Writable again once init fully exited.
// - Read anytime; writes limited while init requested or acknowledged.
// - Init request aborts transfer, then acknowledges.
module cc0_ctrl
  import cc0_pkg::*;
#(
  parameter int INIT_DELAY = CC0_INIT_DELAY_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Protocol engine events, same clock
  input wire logic rx_valid_frame_i,
  input wire logic rx_active_i,
  input wire logic bus_synced_i,
  input wire logic bit_tick_i,
  input wire logic msg_acked_i,
  input wire logic transfer_idle_i,
  // Chip level wait mode, from another domain
  input wire logic cpu_wait_i,
  // Outputs to the controller
  output logic init_request_o,
  output logic init_acknowledge_o,
  output logic abort_transfer_o,
  output logic bus_if_clk_stop_o,
  output logic stamp_we_o,
  output logic [CC0_TS_W-1:0] stamp_data_o,
  output logic irq_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    // These fields hold the registered bus answer.
    logic [31:0] rdata;
    logic ack;
    // These fields are the bits of the control register.
    logic received_frame_flag;
    logic receiver_active_status;
    logic stopwait;
    logic sync;
    logic timer_en;
    logic wake;
    logic sleep;
    logic init_request;
    // These fields track the init handshake.
    logic init_acknowledge;
    logic [7:0] init_cnt;
    // These fields belong to the timestamp timer.
    logic [CC0_TS_W-1:0] timer;
    logic stamp_we;
    logic [CC0_TS_W-1:0] stamp;
    // These fields hold the interrupt status and mask.
    logic [CC0_IRQ_W-1:0] irq_sts;
    logic [CC0_IRQ_W-1:0] irq_msk;
    logic irq;
    // These fields drive the controller strobes and sync the wait pin.
    logic abort;
    logic clk_stop;
    logic wait_s1;
    logic wait_s2;
  } cc0_state_t;

  cc0_state_t st_ff;
  cc0_state_t nxt_st;

  // Field positions come from the package so the map has a single source.
  function automatic logic [7:0] cc0_ctrl_byte(input cc0_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[CC0_BIT_RECEIVED_FRAME_FLAG] = s.received_frame_flag;
    b[CC0_BIT_RECEIVER_ACTIVE_STATUS] = s.receiver_active_status;
    b[CC0_BIT_STOPWAIT] = s.stopwait;
    b[CC0_BIT_SYNC] = s.sync;
    b[CC0_BIT_TIMER] = s.timer_en;
    b[CC0_BIT_WAKE] = s.wake;
    b[CC0_BIT_SLEEP] = s.sleep;
    b[CC0_BIT_INIT_REQUEST] = s.init_request;
    cc0_ctrl_byte = b;
  endfunction

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  // one address decode
  function automatic logic cc0_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    cc0_hit = (adr == reg_adr);
  endfunction

  function automatic logic [31:0] cc0_read_word(input logic [7:0] adr, input cc0_state_t s);
    logic [31:0] word;
    word = CC0_WORD_ZERO;
    unique case (adr)
      CC0_ADDR_CTRL0: begin
        word = {24'h000000, cc0_ctrl_byte(s)};
      end
      CC0_ADDR_IRQ_STATUS: begin
        word = {29'h0, s.irq_sts};
      end
      CC0_ADDR_IRQ_MASK: begin
        word = {29'h0, s.irq_msk};
      end
      CC0_ADDR_TIMESTAMP: begin
        word = {16'h0000, s.timer};
      end
      CC0_ADDR_INIT: begin
        word = {30'h0, s.init_acknowledge, s.init_request};
      end
      default: begin
        // Unmapped addresses read zero so a stray read cannot leak state.
        word = CC0_WORD_ZERO;
      end
    endcase
    cc0_read_word = word;
  endfunction

  function automatic logic [CC0_IRQ_W-1:0] cc0_status_next(
    input logic [CC0_IRQ_W-1:0] cur,
    input logic [CC0_IRQ_W-1:0] set,
    input logic clr
  );
    logic [CC0_IRQ_W-1:0] res;
    res = cur | set;
    if (clr) begin
      // Set wins over the read clear, so no event is lost to a racing read.
      res = set;
    end
    cc0_status_next = res;
  endfunction

  function automatic logic [CC0_TS_W-1:0] cc0_timer_next(
    input logic [CC0_TS_W-1:0] cur,
    input logic en,
    input logic tick
  );
    logic [CC0_TS_W-1:0] res;
    res = cur;
    if (tick) begin
      res = cur + 16'h0001;
    end
    if (!en) begin
      res = CC0_TS_RESET;
    end
    cc0_timer_next = res;
  endfunction

  // ----------------------------------------
  // Bus qualifiers
  // ----------------------------------------
  logic req;
  logic wr;
  logic rd;
  logic in_init;
  logic ctrl_open;
  logic wr_ctrl;
  logic wr_ctrl_open;
  logic wr_mask;
  logic rd_status;
  logic sync_rise;
  logic stamp_now;
  logic [CC0_IRQ_W-1:0] ev;

  // A request is taken only while ack is low, so every access is answered once.
  assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  // Byte lane zero carries every writable bit, so the other lanes are ignored.
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign in_init = st_ff.init_request & st_ff.init_acknowledge;
  assign ctrl_open = ~st_ff.init_request & ~st_ff.init_acknowledge;
  assign wr_ctrl = wr & cc0_hit(wb_adr_i, CC0_ADDR_CTRL0);
  assign wr_ctrl_open = wr_ctrl & ctrl_open;
  assign wr_mask = wr & cc0_hit(wb_adr_i, CC0_ADDR_IRQ_MASK);
  assign rd_status = rd & cc0_hit(wb_adr_i, CC0_ADDR_IRQ_STATUS);
  assign sync_rise = bus_synced_i & ~st_ff.sync & ~st_ff.init_request;
  assign stamp_now = st_ff.timer_en & msg_acked_i;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stamp_we = 1'b0;
    ev = CC0_IRQ_RESET;
    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    // Read data is registered and stands until the next read.
    nxt_st.ack = req;
    if (rd) begin
      nxt_st.rdata = cc0_read_word(wb_adr_i, st_ff);
    end
    // ----------------------------------------
    // Wait synchroniser
    // ----------------------------------------
    // Wait comes from another domain, so only the second stage is read.
    nxt_st.wait_s1 = cpu_wait_i;
    nxt_st.wait_s2 = st_ff.wait_s1;
    // ----------------------------------------
    // Control writes
    // ----------------------------------------
    // init request writable always
    if (wr_ctrl) begin
      // Init request cannot drop before acknowledge, so a half entry never sticks.
      if (wb_dat_i[CC0_BIT_INIT_REQUEST] || in_init) begin
        nxt_st.init_request = wb_dat_i[CC0_BIT_INIT_REQUEST];
      end
      nxt_st.wake = wb_dat_i[CC0_BIT_WAKE];
      nxt_st.sleep = wb_dat_i[CC0_BIT_SLEEP];
    end
    if (wr_ctrl_open) begin
      nxt_st.stopwait = wb_dat_i[CC0_BIT_STOPWAIT];
      nxt_st.timer_en = wb_dat_i[CC0_BIT_TIMER];
      if (wb_dat_i[CC0_BIT_RECEIVED_FRAME_FLAG]) begin
        nxt_st.received_frame_flag = 1'b0;
      end
    end
    if (wr_mask) begin
      nxt_st.irq_msk = wb_dat_i[CC0_IRQ_W-1:0];
    end
    // ----------------------------------------
    // Front end status
    // ----------------------------------------
    // front end drives
    nxt_st.receiver_active_status = rx_active_i & ~st_ff.init_request;
    nxt_st.sync = bus_synced_i & ~st_ff.init_request;
    if (sync_rise) begin
      ev[CC0_IRQ_SYNC] = 1'b1;
    end
    // sticky received flag
    // A frame and a write-one clear in one cycle leave the flag set.
    if (rx_valid_frame_i && !in_init) begin
      nxt_st.received_frame_flag = 1'b1;
      ev[CC0_IRQ_RXFRAME] = 1'b1;
    end
    // ----------------------------------------
    // Init handshake
    // ----------------------------------------
    // abort then acknowledge
    nxt_st.abort = st_ff.init_request & ~st_ff.init_acknowledge;
    if (st_ff.init_request && !st_ff.init_acknowledge) begin
      if (transfer_idle_i && st_ff.init_cnt >= 8'(INIT_DELAY)) begin
        nxt_st.init_acknowledge = 1'b1;
      end else begin
        nxt_st.init_cnt = st_ff.init_cnt + 8'h01;
      end
    end
    // Dropping the request leaves init at once and restarts the settle count.
    if (!st_ff.init_request) begin
      nxt_st.init_acknowledge = 1'b0;
      nxt_st.init_cnt = 8'h00;
    end
    if (in_init) begin
      nxt_st.received_frame_flag = 1'b0;
      nxt_st.stopwait = 1'b0;
      nxt_st.timer_en = 1'b0;
    end
    // ----------------------------------------
    // Timestamp timer
    // ----------------------------------------
    // bit rate counter
    nxt_st.timer = cc0_timer_next(st_ff.timer, st_ff.timer_en, bit_tick_i);
    if (stamp_now) begin
      nxt_st.stamp_we = 1'b1;
      nxt_st.stamp = st_ff.timer;
      ev[CC0_IRQ_STAMP] = 1'b1;
    end
    // ----------------------------------------
    // Clock gating
    // ----------------------------------------
    // The gate lags the wait pin by the synchroniser, so a very short wait may not gate.
    // gate bus clocks in wait
    nxt_st.clk_stop = st_ff.stopwait & st_ff.wait_s2;
    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // A read clears status, but a same-cycle event survives.
    nxt_st.irq_sts = cc0_status_next(st_ff.irq_sts, ev, rd_status);
    // The new status is masked so a fresh event raises the line at the next edge.
    nxt_st.irq = |(nxt_st.irq_sts & st_ff.irq_msk);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // zero after reset
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is taken straight from the state register.
  assign wb_dat_o = st_ff.rdata;
  assign wb_ack_o = st_ff.ack;
  assign init_request_o = st_ff.init_request;
  assign init_acknowledge_o = st_ff.init_acknowledge;
  assign abort_transfer_o = st_ff.abort;
  assign bus_if_clk_stop_o = st_ff.clk_stop;
  assign stamp_we_o = st_ff.stamp_we;
  assign stamp_data_o = st_ff.stamp;
  assign irq_o = st_ff.irq;
endmodule

// >>> dv/cc0_ctrl_checker.sv
// Port assertions for the CAN control register zero block.
`timescale 1ns/1ps
module cc0_ctrl_checker (
  // Watched ports
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic msg_acked_i,
  input wire logic transfer_idle_i,
  input wire logic cpu_wait_i,
  input wire logic init_request_o,
  input wire logic init_acknowledge_o,
  input wire logic abort_transfer_o,
  input wire logic bus_if_clk_stop_o,
  input wire logic stamp_we_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_pulse: assert property (s_req |=> s_pulse)
    else $error("ack not one pulse");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_abort_req: assert property ($rose(init_request_o) |-> ##[0:1] abort_transfer_o)
    else $error("no abort on init request");
  a_abort_end: assert property (
    $fell(abort_transfer_o) |-> init_acknowledge_o || !init_request_o)
    else $error("abort ended early");
  a_init_acknowledge_idle: assert property (
    $rose(init_acknowledge_o) |-> init_request_o && $past(transfer_idle_i))
    else $error("init ack while busy");
  a_init_acknowledge_drop: assert property (!init_request_o |=> !init_acknowledge_o)
    else $error("init ack without request");
  a_stamp_cause: assert property (
    stamp_we_o |-> $past(msg_acked_i) || $past(msg_acked_i, 2))
    else $error("stamp without acknowledge");
  a_stop_wait: assert property (bus_if_clk_stop_o |-> $past(cpu_wait_i, 3))
    else $error("clock stop outside wait");
endmodule
bind cc0_ctrl cc0_ctrl_checker u_chk (.*);

// >>> dv/cc0_engine_model.sv
// Behavioural CAN protocol engine driving the event inputs of the block.
`timescale 1ns/1ps
module cc0_engine_model (
  // Clock, reset and commands
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic rx_go,
  input wire logic tx_go,
  input wire logic abort_transfer_o,
  // Engine events
  output logic rx_valid_frame_i,
  output logic rx_active_i,
  output logic bus_synced_i,
  output logic bit_tick_i,
  output logic msg_acked_i,
  output logic transfer_idle_i
);
  logic [3:0] len_ff;
  logic rx_ff;
  assign rx_active_i = rx_ff && (len_ff != 4'h0);
  assign transfer_idle_i = (len_ff == 4'h0);
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {len_ff, rx_ff, bit_tick_i, rx_valid_frame_i, msg_acked_i, bus_synced_i} <= '0;
    end else begin
      bit_tick_i <= !bit_tick_i;
      rx_valid_frame_i <= rx_ff && (len_ff == 4'h1);
      msg_acked_i <= (len_ff == 4'h1);
      // Abort drops the frame and the sync.
      bus_synced_i <= !abort_transfer_o && (bus_synced_i || bit_tick_i);
      if (abort_transfer_o) len_ff <= 4'h0;
      else if (rx_go || tx_go) begin
        len_ff <= 4'hc;
        rx_ff <= rx_go;
      end else if (len_ff != 4'h0) len_ff <= len_ff - 4'h1;
    end
  end
endmodule

// >>> dv/test_can_ctrl0_status_timestamp.sv
// Self-checking bench for the CAN control register zero block.
`timescale 1ns/1ps
module test_can_ctrl0_status_timestamp;
  import cc0_pkg::*;
  logic clk_sys_i = '0, reset_n_i = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
  logic cpu_wait_i = '0, rx_go = '0, tx_go = '0, wb_ack_o, irq_o, init_request_o;
  logic init_acknowledge_o, abort_transfer_o, bus_if_clk_stop_o, stamp_we_o;
  logic rx_valid_frame_i, rx_active_i, bus_synced_i, bit_tick_i, msg_acked_i, transfer_idle_i;
  logic [7:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic [15:0] stamp_data_o, q;
  int failures = 0, checks = 0, cycles = 0;
  cc0_ctrl #(.INIT_DELAY(4)) DUT (.*);
  cc0_engine_model u_eng (.*);
  initial forever #2 clk_sys_i = !clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      final_report;
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_sys_i);
  endtask
  task automatic frame(input logic rx);
    rx_go <= rx;
    tx_go <= !rx;
    @(posedge clk_sys_i);
    rx_go <= 1'h0;
    tx_go <= 1'h0;
    @(posedge clk_sys_i);
    wb(1'h0, CC0_ADDR_CTRL0, 8'h0);
    check(q[6], rx);
    do @(posedge clk_sys_i); while (rx_active_i || !transfer_idle_i);
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic final_report;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    @(posedge clk_sys_i);
    wb(1'h0, CC0_ADDR_CTRL0, 8'h0);
    check(q & 16'hef, 16'h0);
    wb(1'h0, 8'h20, 8'h0);
    check(q, 16'h0);
    $display("reset test done");
    frame(1'h1);
    wb(1'h1, CC0_ADDR_CTRL0, 8'h0);
    wb(1'h0, CC0_ADDR_CTRL0, 8'h0);
    check(q & 16'h90, 16'h90);
    check(irq_o, 1'h0);
    wb(1'h1, CC0_ADDR_IRQ_MASK, 8'h1);
    @(posedge clk_sys_i);
    check(irq_o, 1'h1);
    wb(1'h0, CC0_ADDR_IRQ_STATUS, 8'h0);
    check(q & 16'h7, 16'h3);
    @(posedge clk_sys_i);
    check(irq_o, 1'h0);
    wb(1'h1, CC0_ADDR_CTRL0, 8'h80);
    wb(1'h0, CC0_ADDR_CTRL0, 8'h0);
    check(q[7], 1'h0);
    frame(1'h0);
    $display("frame test done");
    wb(1'h1, CC0_ADDR_CTRL0, 8'h08);
    frame(1'h0);
    check(stamp_data_o == 16'h0, 1'h0);
    wb(1'h1, CC0_ADDR_CTRL0, 8'h0);
    wb(1'h0, CC0_ADDR_TIMESTAMP, 8'h0);
    check(q, 16'h0);
    $display("timer test done");
    wb(1'h1, CC0_ADDR_CTRL0, 8'h28);
    wb(1'h1, CC0_ADDR_CTRL0, 8'h29);
    do @(posedge clk_sys_i); while (init_acknowledge_o !== 1'h1);
    wb(1'h1, CC0_ADDR_CTRL0, 8'ha9);
    wb(1'h0, CC0_ADDR_CTRL0, 8'h0);
    check(q, 16'h01);
    wb(1'h0, CC0_ADDR_INIT, 8'h0);
    check(q, 16'h03);
    wb(1'h1, CC0_ADDR_CTRL0, 8'h0);
    wb(1'h1, CC0_ADDR_CTRL0, 8'h20);
    wb(1'h0, CC0_ADDR_CTRL0, 8'h0);
    check(q & 16'hef, 16'h20);
    cpu_wait_i <= 1'h1;
    repeat (5) @(posedge clk_sys_i);
    check(bus_if_clk_stop_o, 1'h1);
    wb(1'h1, CC0_ADDR_CTRL0, 8'h0);
    repeat (2) @(posedge clk_sys_i);
    check(bus_if_clk_stop_o, 1'h0);
    $display("init test done");
    final_report;
  end
endmodule
